// ==== hw/station_mode_regs.svh ====
`ifndef STATION_MODE_REGS_SVH
`define STATION_MODE_REGS_SVH

// register indices on the control register port
`define SAMC_IDX_ADDR_MID 7'h0d
`define SAMC_IDX_ADDR_HIGH 7'h0e
`define SAMC_IDX_MODE 7'h0f

// operating mode field positions
`define SAMC_ACCEPT_ALL_BIT 15
`define SAMC_BCAST_DIS_BIT 14
`define SAMC_OWN_MATCH_DIS_BIT 13
`define SAMC_LINK_MON_DIS_BIT 12
`define SAMC_POL_CORR_DIS_BIT 11
`define SAMC_CODEC_LOOP_BIT 10
`define SAMC_THR_IDLE_BIT 9
`define SAMC_PORT_SEL_HI 8
`define SAMC_PORT_SEL_LO 7
`define SAMC_INT_LOOP_BIT 6
`define SAMC_RETRY_DIS_BIT 5
`define SAMC_FORCE_COLL_BIT 4
`define SAMC_LOOP_BIT 2

// reset values; the reset pin clears bits 14, 9, 8-7 and 2
`define SAMC_MODE_RESET 16'h0000
`define SAMC_MODE_PIN_CLEAR 16'h4384
`define SAMC_ADDR_RESET 16'h0000

// transmission attempts
`define SAMC_ATTEMPTS_RETRY 5'h10
`define SAMC_ATTEMPTS_SINGLE 5'h01

// station address length in bits
`define SAMC_ADDR_BITS 48
`define SAMC_ADDR_LAST 6'h2f

`endif

// ==== hw/samc_pkg.sv ====
package samc_pkg;

  // network port as decoded from the two select bits
  typedef enum logic [1:0] {
    port_aui = 2'b00,
    port_twisted_pair = 2'b01,
    port_serial = 2'b10,
    port_reserved = 2'b11
  } port_t;

  // loopback arrangement
  typedef enum logic [1:0] {
    loop_none = 2'b00,
    loop_external = 2'b01,
    loop_internal_codec = 2'b11,
    loop_internal_no_codec = 2'b10
  } loop_mode_t;

  // station address serializer
  typedef enum logic {
    ser_idle = 1'b0,
    ser_shift = 1'b1
  } ser_state_t;

endpackage : samc_pkg

// ==== hw/mode_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface mode_if;
  logic [15:0] mode;
  logic ext_sel_en;
  logic medium_pin;
  samc_pkg::port_t active_port;
  samc_pkg::loop_mode_t loop_mode;
  logic tp_sel;
  logic aui_sel;
  logic force_coll_active;

  modport ctrl (
    output mode, ext_sel_en, medium_pin,
    input active_port, loop_mode, tp_sel, aui_sel, force_coll_active
  );
  modport dec (
    input mode, ext_sel_en, medium_pin,
    output active_port, loop_mode, tp_sel, aui_sel, force_coll_active
  );
endinterface : mode_if

`default_nettype wire

// ==== hw/mode_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "station_mode_regs.svh"

module mode_decode (
  mode_if.dec m // mode word in, decoded selections out
);
  logic loop_on;
  logic int_loop;
  logic codec_loop;
  samc_pkg::port_t sw_port;

  assign loop_on = m.mode[`SAMC_LOOP_BIT];
  assign int_loop = m.mode[`SAMC_INT_LOOP_BIT];
  assign codec_loop = m.mode[`SAMC_CODEC_LOOP_BIT];
  assign sw_port = samc_pkg::port_t'(
    m.mode[`SAMC_PORT_SEL_HI:`SAMC_PORT_SEL_LO]);

  // port choice; with the override on, pin high picks twisted pair, low picks aui, else the mode bits pick
  always_comb begin
    if (m.ext_sel_en) begin
      m.active_port = m.medium_pin ? samc_pkg::port_twisted_pair
                                   : samc_pkg::port_aui;
    end else begin
      m.active_port = sw_port;
    end
  end

  // reserved code selects neither analog port
  assign m.tp_sel = (m.active_port == samc_pkg::port_twisted_pair);
  assign m.aui_sel = (m.active_port == samc_pkg::port_aui);

  // loopback arrangement from the three loop bits
  always_comb begin
    if (!loop_on) begin
      m.loop_mode = samc_pkg::loop_none;
    end else if (!int_loop) begin
      m.loop_mode = samc_pkg::loop_external;
    end else if (!codec_loop) begin
      m.loop_mode = samc_pkg::loop_internal_codec;
    end else begin
      m.loop_mode = samc_pkg::loop_internal_no_codec;
    end
  end

  // forced collision is only valid under internal loopback
  assign m.force_coll_active = m.mode[`SAMC_FORCE_COLL_BIT] && loop_on
    && int_loop;

endmodule : mode_decode

`default_nettype wire

// ==== hw/station_address_and_mode_control.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "station_mode_regs.svh"

module station_address_and_mode_control #(
  parameter int IDX_W = 7 // width of the register index
) (
  input wire logic ref_clk, // controller clock, 200 mhz
  input wire logic rst_b, // reset pin, active low
  input wire logic stopped, // controller is in the stopped state
  input wire logic [IDX_W-1:0] csr_index, // register index of access
  input wire logic csr_write, // host write strobe
  input wire logic csr_read, // host read strobe
  input wire logic [15:0] csr_wdata, // host write data
  output logic [15:0] csr_rdata, // registered read data
  output logic csr_rvalid, // read data valid pulse
  output logic csr_hit, // index belongs to this block
  input wire logic init_load, // initialization block load strobe
  input wire logic [15:0] init_addr_mid, // block value, address mid word
  input wire logic [15:0] init_addr_high, // block value, address high word
  input wire logic [15:0] init_mode, // block value, mode word
  input wire logic [15:0] station_address_low, // low word kept elsewhere
  input wire logic ext_medium_select_enable, // configuration bit
  input wire logic medium_select_pin, // jumper pin level
  input wire logic addr_send_start, // begin serializing the address
  input wire logic addr_bit_ready, // link takes one address bit
  output logic addr_bit, // current address bit
  output logic addr_bit_valid, // address bit on addr_bit is valid
  output logic addr_send_done, // last bit taken pulse
  output logic station_address_valid, // both upper words are defined
  output logic [47:0] station_address, // full station address
  output logic accept_all_frames, // promiscuous receive
  output logic broadcast_receive_disable, // ignore broadcasts
  output logic own_address_match_disable, // skip own address match
  output logic link_monitor_enable, // monitor link pulses
  output logic polarity_correction_enable, // auto polarity correction
  output logic low_receive_threshold, // reduced twisted pair threshold
  output logic aui_idle_high, // aui driver rests high at idle
  output samc_pkg::port_t network_port, // active network port
  output samc_pkg::loop_mode_t loopback_mode, // loopback arrangement
  output logic force_collision_active, // collide on each internal loopback attempt
  output logic [4:0] max_attempts, // transmission attempts per frame
  output logic [15:0] operating_mode // raw mode word
);

  // the index must at least reach the highest register
  if (IDX_W < 4) begin : g_idx_check
    $error("IDX_W too narrow for the register indices");
  end

  // address length and the serializer's end count must agree
  if (`SAMC_ADDR_LAST != `SAMC_ADDR_BITS - 1) begin : g_len_check
    $error("serializer end count does not match the address length");
  end

  // a reset value setting a pin-cleared bit would disagree with the reset pin
  if (|(`SAMC_MODE_RESET & `SAMC_MODE_PIN_CLEAR)) begin : g_rst_check
    $error("mode reset value sets a pin-cleared bit");
  end

  // register state
  logic [15:0] station_address_mid_word;
  logic [15:0] station_address_high_word;
  logic [15:0] mode_word;
  logic mid_defined;
  logic high_defined;
  logic [15:0] next_station_address_mid_word;
  logic [15:0] next_station_address_high_word;
  logic [15:0] next_mode_word;
  logic next_mid_defined;
  logic next_high_defined;

  // read path state
  logic [15:0] next_csr_rdata;
  logic next_csr_rvalid;

  // serializer state
  samc_pkg::ser_state_t ser_state;
  samc_pkg::ser_state_t next_ser_state;
  logic [47:0] ser_shift;
  logic [47:0] next_ser_shift;
  logic [5:0] ser_count;
  logic [5:0] next_ser_count;
  logic next_addr_send_done;
  logic last_bit;

  // decoder hookup: mode word and pin override in, port and loop out
  mode_if m ();

  // index decode shared by the read and write paths
  function automatic logic [2:0] decode_index(input logic [IDX_W-1:0] idx);
    logic [2:0] sel;
    // zero means the index belongs to another block
    sel = 3'h0;
    if (idx == IDX_W'(`SAMC_IDX_ADDR_MID)) begin
      sel = 3'h1;
    end else if (idx == IDX_W'(`SAMC_IDX_ADDR_HIGH)) begin
      sel = 3'h2;
    end else if (idx == IDX_W'(`SAMC_IDX_MODE)) begin
      sel = 3'h4;
    end
    return sel;
  endfunction : decode_index

  // register select and the write qualifier
  logic [2:0] sel;
  logic host_wr;

  assign sel = decode_index(csr_index);
  assign csr_hit = (sel != 3'h0);
  // running controller ignores host writes entirely
  assign host_wr = csr_write && stopped && csr_hit;

  // next register values; an init load outranks a host write
  always_comb begin
    next_station_address_mid_word = station_address_mid_word;
    next_station_address_high_word = station_address_high_word;
    next_mode_word = mode_word;
    next_mid_defined = mid_defined;
    next_high_defined = high_defined;
    if (init_load) begin
      next_station_address_mid_word = init_addr_mid;
      next_station_address_high_word = init_addr_high;
      next_mode_word = init_mode;
      next_mid_defined = 1'b1;
      next_high_defined = 1'b1;
      // a colliding host write is dropped, not delayed
    end else if (host_wr) begin
      if (sel[0]) begin
        next_station_address_mid_word = csr_wdata;
        next_mid_defined = 1'b1;
      end
      if (sel[1]) begin
        next_station_address_high_word = csr_wdata;
        next_high_defined = 1'b1;
      end
      if (sel[2]) begin
        next_mode_word = csr_wdata;
      end
    end
  end

  // reset clears every mode bit, the pin-cleared ones among them
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      station_address_mid_word <= `SAMC_ADDR_RESET;
      station_address_high_word <= `SAMC_ADDR_RESET;
      mode_word <= `SAMC_MODE_RESET;
      mid_defined <= 1'b0;
      high_defined <= 1'b0;
    end else begin
      station_address_mid_word <= next_station_address_mid_word;
      station_address_high_word <= next_station_address_high_word;
      mode_word <= next_mode_word;
      mid_defined <= next_mid_defined;
      high_defined <= next_high_defined;
    end
  end

  // reads while running or at a foreign index return zero
  always_comb begin
    next_csr_rdata = 16'h0000;
    next_csr_rvalid = csr_read;
    if (csr_read && stopped) begin
      unique case (sel)
        3'h1: next_csr_rdata = station_address_mid_word;
        3'h2: next_csr_rdata = station_address_high_word;
        3'h4: next_csr_rdata = mode_word;
        default: next_csr_rdata = 16'h0000;
      endcase
    end
  end

  // read answer registered so the data comes from flip-flops
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      csr_rdata <= 16'h0000;
      csr_rvalid <= 1'b0;
    end else begin
      csr_rdata <= next_csr_rdata;
      csr_rvalid <= next_csr_rvalid;
    end
  end

  // mode decoding lives in its own module
  assign m.mode = mode_word;
  assign m.ext_sel_en = ext_medium_select_enable;
  assign m.medium_pin = medium_select_pin;

  mode_decode u_decode (
    .m(m.dec)
  );

  // static control outputs from the stored mode word; the port also follows the medium pin
  assign operating_mode = mode_word;
  assign network_port = m.active_port;
  assign loopback_mode = m.loop_mode;
  assign force_collision_active = m.force_coll_active;
  assign accept_all_frames = mode_word[`SAMC_ACCEPT_ALL_BIT];
  assign broadcast_receive_disable =
    mode_word[`SAMC_BCAST_DIS_BIT];
  assign own_address_match_disable =
    mode_word[`SAMC_OWN_MATCH_DIS_BIT];

  // bit 9 is one stored bit with two meanings, one per port
  logic thr_idle;
  assign thr_idle = mode_word[`SAMC_THR_IDLE_BIT];

  // port-specific controls are held off on the other ports
  assign link_monitor_enable = m.tp_sel
    && !mode_word[`SAMC_LINK_MON_DIS_BIT];
  assign polarity_correction_enable = m.tp_sel
    && !mode_word[`SAMC_POL_CORR_DIS_BIT];
  assign low_receive_threshold = m.tp_sel
    && thr_idle;
  assign aui_idle_high = m.aui_sel
    && thr_idle;

  // retry count for the transmit engine
  assign max_attempts = mode_word[`SAMC_RETRY_DIS_BIT]
    ? `SAMC_ATTEMPTS_SINGLE : `SAMC_ATTEMPTS_RETRY;

  // full address; the low word is held outside this block
  assign station_address = {station_address_high_word,
                            station_address_mid_word, station_address_low};
  assign station_address_valid = mid_defined && high_defined;

  // end count compared once, outside the next-state logic
  assign last_bit = (ser_count == `SAMC_ADDR_LAST);

  // serializer: loads a snapshot so later writes cannot tear a frame
  always_comb begin
    next_ser_state = ser_state;
    next_ser_shift = ser_shift;
    next_ser_count = ser_count;
    next_addr_send_done = 1'b0;
    unique case (ser_state)
      samc_pkg::ser_idle: begin
        // an undefined address is never sent
        if (addr_send_start && station_address_valid) begin
          next_ser_state = samc_pkg::ser_shift;
          next_ser_shift = station_address;
          next_ser_count = 6'h00;
        end
      end
      samc_pkg::ser_shift: begin
        // a stalled link simply holds the current bit
        if (addr_bit_ready) begin
          next_ser_shift = {1'b0, ser_shift[47:1]};
          next_ser_count = ser_count + 6'h01;
          if (last_bit) begin
            next_ser_state = samc_pkg::ser_idle;
            next_addr_send_done = 1'b1;
          end
        end
      end
    endcase
  end

  // serializer flops; a reset in mid send drops the frame silently
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ser_state <= samc_pkg::ser_idle;
      ser_shift <= 48'h000000000000;
      ser_count <= 6'h00;
      addr_send_done <= 1'b0;
    end else begin
      ser_state <= next_ser_state;
      ser_shift <= next_ser_shift;
      ser_count <= next_ser_count;
      addr_send_done <= next_addr_send_done;
    end
  end

  // bit 0 of the snapshot is always the next to go out
  assign addr_bit = ser_shift[0];
  assign addr_bit_valid = (ser_state == samc_pkg::ser_shift);

endmodule : station_address_and_mode_control

`default_nettype wire

// ==== sim/addr_sink.sv ====
`timescale 1ns/1ps
`default_nettype none

module addr_sink (
  input wire logic ref_clk, // clock
  input wire logic rst_b, // reset, active low
  input wire logic addr_bit, // bit on offer
  input wire logic addr_bit_valid, // offer valid
  input wire logic slow, // stall at random
  output logic addr_bit_ready, // bit taken at edge
  output logic [47:0] got // gathered, first bit ends at bit 0
);
  // shift in from the top so the first bit lands lowest
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_bit_ready <= 1'b0;
      got <= 48'h0;
    end else begin
      if (addr_bit_valid && addr_bit_ready) begin
        got <= {addr_bit, got[47:1]};
      end
      addr_bit_ready <= slow ? 1'($urandom) : 1'b1;
    end
  end
endmodule : addr_sink

`default_nettype wire

// ==== sim/samc_chk.sv ====
`timescale 1ns/1ps
`default_nettype none

module samc_chk #(
  parameter int IDX_W = 7 // index width
) (
  input wire logic ref_clk, // clock
  input wire logic rst_b, // reset
  input wire logic stopped, // stop state
  input wire logic [IDX_W-1:0] csr_index, // index
  input wire logic csr_write, // write
  input wire logic csr_read, // read
  input wire logic [15:0] csr_wdata, // wdata
  input wire logic [15:0] csr_rdata, // rdata
  input wire logic csr_rvalid, // rvalid
  input wire logic init_load, // load strobe
  input wire logic [15:0] init_mode, // load value
  input wire logic ext_medium_select_enable, // override
  input wire logic medium_select_pin, // pin
  input wire logic addr_send_start, // start
  input wire logic addr_bit, // bit
  input wire logic addr_bit_valid, // bit valid
  input wire logic station_address_valid, // defined
  input wire logic [47:0] station_address, // address
  input wire logic low_receive_threshold, // threshold
  input wire logic aui_idle_high, // idle level
  input wire samc_pkg::port_t network_port, // port
  input wire samc_pkg::loop_mode_t loopback_mode, // loopback
  input wire logic force_collision_active, // collide
  input wire logic [4:0] max_attempts, // attempts
  input wire logic [15:0] operating_mode // mode word
);
  // single domain, so one clock and one disable for all
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_write_lands: assert property (
    (csr_write && stopped && !init_load && csr_index == IDX_W'(7'h0f))
    |=> operating_mode == $past(csr_wdata)) else $error("mode write lost");
  a_running_frozen: assert property (
    (csr_write && !stopped && !init_load) |=> $stable(operating_mode))
    else $error("mode changed while running");
  a_init_copies: assert property (
    init_load |=> operating_mode == $past(init_mode) && station_address_valid)
    else $error("init load not copied");
  a_read_refused: assert property (
    (csr_read && !stopped) |=> csr_rvalid && csr_rdata == 16'h0000)
    else $error("read while running not zero");
  a_port_decode: assert property (
    network_port == (ext_medium_select_enable ? (medium_select_pin ?
    samc_pkg::port_twisted_pair : samc_pkg::port_aui) :
    samc_pkg::port_t'(operating_mode[8:7]))) else $error("port wrong");
  a_bit9_split: assert property (
    low_receive_threshold == (operating_mode[9] &&
    network_port == samc_pkg::port_twisted_pair) && aui_idle_high ==
    (operating_mode[9] && network_port == samc_pkg::port_aui))
    else $error("bit 9 meaning wrong");
  a_loop_mode: assert property (
    loopback_mode == (!operating_mode[2] ? samc_pkg::loop_none :
    !operating_mode[6] ? samc_pkg::loop_external : operating_mode[10] ?
    samc_pkg::loop_internal_no_codec : samc_pkg::loop_internal_codec))
    else $error("loopback decode wrong");
  a_force_coll: assert property (
    force_collision_active == (operating_mode[4] && operating_mode[2] &&
    operating_mode[6])) else $error("force collision wrong");
  a_attempt_count: assert property (
    max_attempts == (operating_mode[5] ? 5'h01 : 5'h10))
    else $error("attempt count wrong");
  a_first_bit: assert property (
    (addr_send_start && !addr_bit_valid && station_address_valid) |=>
    addr_bit_valid && addr_bit == $past(station_address[0]))
    else $error("first bit not bit 0");
endmodule : samc_chk

bind station_address_and_mode_control samc_chk #(.IDX_W(IDX_W)) samc_chk_i (
  .ref_clk, .rst_b, .stopped, .csr_index, .csr_write, .csr_read, .csr_wdata,
  .csr_rdata, .csr_rvalid, .init_load, .init_mode, .ext_medium_select_enable,
  .medium_select_pin, .addr_send_start, .addr_bit, .addr_bit_valid,
  .station_address_valid, .station_address, .low_receive_threshold,
  .aui_idle_high, .network_port, .loopback_mode, .force_collision_active,
  .max_attempts, .operating_mode);

`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic ref_clk = 1'b0, rst_b = 1'b0, stopped = 1'b1, csr_write = 1'b0;
  logic csr_read = 1'b0, init_load = 1'b0, addr_send_start = 1'b0;
  logic ext_medium_select_enable = 1'b0, medium_select_pin = 1'b0;
  logic slow = 1'b0;
  logic [6:0] csr_index = 7'h00;
  logic [15:0] csr_wdata = 16'h0, init_addr_mid = 16'h0;
  logic [15:0] init_addr_high = 16'h0, init_mode = 16'h0;
  logic [15:0] station_address_low = 16'h0;
  logic [15:0] csr_rdata, operating_mode;
  logic csr_rvalid, csr_hit, addr_bit_ready, addr_bit, addr_bit_valid;
  logic addr_send_done, station_address_valid, accept_all_frames;
  logic broadcast_receive_disable, own_address_match_disable;
  logic link_monitor_enable, polarity_correction_enable;
  logic low_receive_threshold, aui_idle_high, force_collision_active;
  logic [47:0] station_address, got;
  logic [4:0] max_attempts;
  samc_pkg::port_t network_port;
  samc_pkg::loop_mode_t loopback_mode;
  logic [47:0] exp_q[$];
  int miscompares = 0;
  int compares = 0;

  // 200 mhz
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  station_address_and_mode_control station_address_and_mode_control_i (.*);
  addr_sink addr_sink_i (.ref_clk, .rst_b, .addr_bit, .addr_bit_valid, .slow,
    .addr_bit_ready, .got);

  task automatic check(input logic [47:0] act, exp, input string what);
    compares++;
    if (act !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, what, act, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // each read answer or finished address send meets the oldest note
  always @(posedge ref_clk) begin
    if (csr_rvalid === 1'b1 || addr_send_done === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(48'h1, 48'h0, "result without note");
      end else begin
        check(csr_rvalid === 1'b1 ? {32'h0, csr_rdata} : got,
          exp_q.pop_front(), "res");
      end
    end
  end

  // inputs move 1 ns after the edge so no race with the design
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [6:0] idx, input logic [15:0] d);
    csr_index = idx;
    csr_wdata = d;
    csr_write = 1'b1;
    tick;
    csr_write = 1'b0;
    tick;
  endtask : wr

  task automatic rd(input logic [6:0] idx, input logic [15:0] e);
    csr_index = idx;
    csr_read = 1'b1;
    exp_q.push_back({32'h0, e});
    tick;
    csr_read = 1'b0;
    check(48'(csr_hit), 48'(idx inside {7'h0d, 7'h0e, 7'h0f}),
      "hit");
    tick;
  endtask : rd

  task automatic check_mode(input logic [15:0] w);
    logic [1:0] p;
    logic tp;
    p = ext_medium_select_enable ? {1'b0, medium_select_pin} : w[8:7];
    tp = p == 2'b01;
    check(48'(operating_mode), 48'(w), "mode");
    check(48'({accept_all_frames, broadcast_receive_disable,
      own_address_match_disable}),
      48'(w[15:13]), "filters");
    check(48'({link_monitor_enable, polarity_correction_enable}),
      48'({tp & ~w[12], tp & ~w[11]}), "tp controls");
    check(48'({network_port, max_attempts, low_receive_threshold,
      aui_idle_high}),
      48'({p, w[5] ? 5'h01 : 5'h10, tp && w[9], p == 2'b00 && w[9]}),
      "port controls");
    check(48'({loopback_mode, force_collision_active}),
      48'({!w[2] ? 2'b00 : !w[6] ? 2'b01 : {1'b1, ~w[10]},
      w[4] & w[2] & w[6]}), "loop controls");
  endtask : check_mode

  initial begin
    logic [15:0] w;
    logic [47:0] a;
    void'($urandom(62192));
    repeat (16) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    tick;
    check(48'({operating_mode, station_address_valid, max_attempts,
      network_port}), 48'({16'h0, 1'b0, 5'h10, 2'b00}),
      "reset");
    $display("test reset state done");
    // host access refused while running
    stopped = 1'b0;
    wr(7'h0f, 16'hffff);
    rd(7'h0f, 16'h0000);
    check(48'(operating_mode), 48'h0, "running write");
    stopped = 1'b1;
    $display("test running refusal done");
    // every port code and loop combination, override on and off
    for (int i = 0; i < 64; i++) begin
      w = 16'($urandom);
      w[8:7] = i[1:0];
      {w[10], w[6], w[2]} = i[4:2];
      ext_medium_select_enable = i[5];
      medium_select_pin = 1'($urandom);
      wr(7'h0f, w);
      rd(7'h0f, w);
      check_mode(w);
    end
    wr(7'h10, 16'h1234);
    rd(7'h10, 16'h0000);
    $display("test mode fields done");
    // init load wins over a host write in the same cycle
    init_addr_mid = 16'($urandom);
    init_addr_high = 16'($urandom);
    init_mode = 16'($urandom);
    station_address_low = 16'($urandom);
    csr_index = 7'h0f;
    csr_wdata = ~init_mode;
    csr_write = 1'b1;
    init_load = 1'b1;
    tick;
    csr_write = 1'b0;
    init_load = 1'b0;
    check_mode(init_mode);
    check(station_address, {init_addr_high, init_addr_mid,
      station_address_low}, "init address");
    $display("test init load done");
    // host-written address sent bit 0 first, prompt then stalling
    a = {16'($urandom), 16'($urandom), 16'($urandom)};
    station_address_low = a[15:0];
    wr(7'h0d, a[31:16]);
    wr(7'h0e, a[47:32]);
    rd(7'h0d, a[31:16]);
    for (int s = 0; s < 2; s++) begin
      slow = s[0];
      exp_q.push_back(a);
      addr_send_start = 1'b1;
      tick;
      addr_send_start = 1'b0;
      for (int n = 0; addr_bit_valid === 1'b1; n++) begin
        if (n == 800) begin
          check(48'h1, 48'h0, "send timeout");
          tally_and_finish;
        end
        tick;
      end
      tick;
    end
    $display("test address send done");
    // reset pin in mid run; override off so the port shows the cleared field
    ext_medium_select_enable = 1'b0;
    wr(7'h0f, 16'hffff);
    rst_b = 1'b0;
    tick;
    rst_b = 1'b1;
    tick;
    check(48'({operating_mode, network_port, station_address_valid}), 48'h0,
      "mid reset");
    check(48'(exp_q.size()), 48'h0, "notes left");
    $display("test mid reset done");
    tally_and_finish;
  end
endmodule : testbench

`default_nettype wire
